// File: shared/ssrb_params.svh
// Purpose: Offsets, field positions, keys and timing of the sensor register bank.
// Assumes: A 20 MHz core clock.
// Notes: Counts are derived from the times in their own units.
`ifndef SSRB_PARAMS_SVH
`define SSRB_PARAMS_SVH
`define SSRB_OFS_WRITE_TARGET 8'h02
`define SSRB_OFS_WRITE_HIGH 8'h04
`define SSRB_OFS_WRITE_LOW 8'h06
`define SSRB_OFS_WRITE_CS 8'h08
`define SSRB_OFS_READ_TARGET 8'h0A
`define SSRB_OFS_READ_CS 8'h0C
`define SSRB_OFS_READ_HIGH 8'h0E
`define SSRB_OFS_READ_LOW 8'h10
`define SSRB_OFS_COMMAND 8'h1E
`define SSRB_OFS_POSITION 8'h20
`define SSRB_OFS_FAULT 8'h24
`define SSRB_OFS_CAUTION 8'h26
`define SSRB_BIT_START 15
`define SSRB_BIT_BUSY 8
`define SSRB_BIT_DONE 0
`define SSRB_BIT_STATUS_WIPE 10
`define SSRB_BIT_CAUTION_WIPE 9
`define SSRB_BIT_FAULT_WIPE 8
`define SSRB_BIT_UVD 3
`define SSRB_BIT_UVA 2
`define SSRB_KEY_MEMORY 8'hA5
`define SSRB_KEY_TURNS 8'h46
`define SSRB_KEY_HARD_RESET 8'h5A
`define SSRB_KEY_TEST 8'hB9
`define SSRB_NVM_FIRST 8'h00
`define SSRB_NVM_LAST 8'h1F
`define SSRB_SHADOW_FIRST 8'h40
`define SSRB_SHADOW_LAST 8'h5F
`define SSRB_FAULT_ID 4'hA
`define SSRB_CAUTION_ID 4'hB
`define SSRB_CLK_HZ 20000000
`define SSRB_NVM_WR_MS 24
`define SSRB_NVM_RD_NS 2000
`define SSRB_NVM_WR_CYC ((`SSRB_NVM_WR_MS * (`SSRB_CLK_HZ / 1000)))
`define SSRB_NVM_RD_CYC ((`SSRB_NVM_RD_NS * (`SSRB_CLK_HZ / 1000000) + 999) / 1000)
`endif

// File: shared/ssrb_pkg.sv
// Purpose: Types of the sensor register bank.
// Assumes: Nothing beyond the parameter header.
// Notes: The state struct is the whole state of the top module.
package ssrb_pkg;
  typedef enum logic [3:0] {
    SSRB_ACT_NONE = 4'h0,
    SSRB_ACT_LOW_MARGIN = 4'h1,
    SSRB_ACT_HIGH_MARGIN = 4'h2,
    SSRB_ACT_TURNS = 4'h3,
    SSRB_ACT_RELOAD = 4'h4,
    SSRB_ACT_IDLE5 = 4'h5,
    SSRB_ACT_HARD_RESET = 4'h6,
    SSRB_ACT_FE_TEST = 4'h7,
    SSRB_ACT_LOGIC_TEST = 4'h8,
    SSRB_ACT_BOTH_TEST = 4'h9
  } ssrb_action_e;

  typedef enum logic [1:0] {
    SSRB_OP_IDLE = 2'b00,
    SSRB_OP_WAIT = 2'b01,
    SSRB_OP_FINISH = 2'b10
  } ssrb_op_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ssrb_req_s;

  typedef struct packed {
    logic [7:0] wr_target;
    logic [15:0] wr_high;
    logic [15:0] wr_low;
    ssrb_op_e wr_op;
    logic [19:0] wr_cnt;
    logic wr_done;
    logic [7:0] rd_target;
    ssrb_op_e rd_op;
    logic [19:0] rd_cnt;
    logic rd_done;
    logic [31:0] rd_data;
    logic [3:0] sel;
    logic act_run;
    logic margin_on;
    logic fe_ok;
    logic lg_ok;
    logic task_done;
    logic boot_done;
    logic reload_run;
    logic [4:0] reload_idx;
    logic [11:0] fault;
    logic [11:0] fault_seen;
    logic [11:0] caution;
    logic [11:0] caution_seen;
    logic [2:0] uvd_sync;
    logic uvd;
    logic [2:0] uva_sync;
    logic uva;
    logic [15:0] rdata;
    logic [15:0] pos_word;
    logic turns_pulse;
    logic reset_pulse;
    logic [31:0][31:0] nvm;
    logic [31:0][31:0] shadow;
  } ssrb_state_s;
endpackage

// File: design/ssrb_top.sv
// Purpose: Register bank of an angle sensor: indirect memory access, command,
//   status clears and the position word.
// Assumes: Requests come one cycle wide from a serial decoder on i_clk.
// Notes: Undervoltage pins are filtered by three flip-flops.
// Notes on behaviour
// - write low word register holds bits 15:0.
// - write start sets busy, clears done, reads zero.
// - write done set at end, cleared by read start.
// - read target low byte; selects memory or shadow.
// - read start sets busy, clears done, reads zero.
// - read done set at end, cleared on restart.
// - read high word shows fetched upper half.
// - read low word shows fetched lower half.
// - action select picks action; key triggers it.
// - margin actions need unlock and key A5.
// - reload copies memory to working state, needs unlock and key A5.
// - hard reset needs unlock; key 5A applies.
// - turns counter reset runs on key 46.
// - self-tests start on B9, both run together.
// - status wipe clears task and boot flags.
// - caution wipe clears only previously read bits.
// - fault wipe clears only previously read bits.
// - error summary is OR of unmasked flags.
// - low supply summary is realtime undervoltage OR.
// - parity bit makes word ones count odd.
// - angle in bits 11:0, bit 15 zero.
// - write memory takes 24 ms, shadow is quick.
// - write high word register holds bits 31:16.
// - task flag drops on trigger, rises on completion.
`timescale 1ns/1ps
`include "ssrb_params.svh"

module ssrb_top
  import ssrb_pkg::*;
#(
  parameter int NVM_WR_CYC = `SSRB_NVM_WR_CYC,
  parameter int NVM_RD_CYC = `SSRB_NVM_RD_CYC
) (
  // Clock, reset and enable.
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Register requests and read data.
  input wire ssrb_req_s i_req,
  output logic [15:0] o_reg_rdata,
  // Sensor state and events.
  input wire logic [11:0] i_angle,
  input wire logic i_unlocked,
  input wire logic i_boot_done,
  input wire logic i_fe_test_done,
  input wire logic i_logic_test_done,
  input wire logic [11:0] i_fault_set,
  input wire logic [11:0] i_caution_set,
  input wire logic [11:0] i_fault_mask,
  input wire logic [11:0] i_caution_mask,
  // Undervoltage pins and their masks.
  input wire logic i_uvd_pin,
  input wire logic i_uva_pin,
  input wire logic [1:0] i_uv_mask,
  // Action and status outputs.
  output logic [15:0] o_position_word,
  output logic o_task_done,
  output logic o_boot_done,
  output logic o_margin_low,
  output logic o_margin_high,
  output logic o_turns_reset,
  output logic o_hard_reset,
  output logic o_fe_test_run,
  output logic o_logic_test_run,
  output logic o_reload_busy
);

  if (NVM_WR_CYC < 2 || NVM_WR_CYC > 1048575) begin : g_bad_wr
    $error("NVM_WR_CYC out of range");
  end
  if (NVM_RD_CYC < 2 || NVM_RD_CYC > 1048575) begin : g_bad_rd
    $error("NVM_RD_CYC out of range");
  end

  localparam logic [19:0] WR_LOAD = 20'(NVM_WR_CYC - 2);
  localparam logic [19:0] RD_LOAD = 20'(NVM_RD_CYC - 2);

  ssrb_state_s s;
  ssrb_state_s next_s;

  function automatic logic in_nvm(input logic [7:0] a);
    return a >= `SSRB_NVM_FIRST && a <= `SSRB_NVM_LAST;
  endfunction

  function automatic logic in_shadow(input logic [7:0] a);
    return a >= `SSRB_SHADOW_FIRST && a <= `SSRB_SHADOW_LAST;
  endfunction

  // Tells whether a key fires the selected action under the lock state.
  function automatic logic key_fires(input logic [3:0] sel, input logic [7:0] key,
                                     input logic unlocked);
    logic ok;
    ok = 1'b0;
    unique case (sel)
      SSRB_ACT_LOW_MARGIN, SSRB_ACT_HIGH_MARGIN, SSRB_ACT_RELOAD: begin
        ok = unlocked && key == `SSRB_KEY_MEMORY;
      end
      SSRB_ACT_HARD_RESET: begin
        ok = unlocked && key == `SSRB_KEY_HARD_RESET;
      end
      SSRB_ACT_TURNS: begin
        ok = key == `SSRB_KEY_TURNS;
      end
      SSRB_ACT_FE_TEST, SSRB_ACT_LOGIC_TEST, SSRB_ACT_BOTH_TEST: begin
        ok = key == `SSRB_KEY_TEST;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  logic ef;
  logic uv;
  logic [15:0] pos;
  logic [15:0] wr_cs;
  logic [15:0] rd_cs;
  logic fe_need;
  logic lg_need;
  logic finish;

  always_comb begin
    ef = |(s.fault & ~i_fault_mask) | |(s.caution & ~i_caution_mask);
    uv = (s.uvd & ~i_uv_mask[1]) | (s.uva & ~i_uv_mask[0]);
    pos = {1'b0, ef, uv, 1'b0, i_angle};
    pos[12] = ~^{ef, uv, i_angle};
    wr_cs = 16'h0000;
    wr_cs[`SSRB_BIT_BUSY] = s.wr_op != SSRB_OP_IDLE;
    wr_cs[`SSRB_BIT_DONE] = s.wr_done;
    rd_cs = 16'h0000;
    rd_cs[`SSRB_BIT_BUSY] = s.rd_op != SSRB_OP_IDLE;
    rd_cs[`SSRB_BIT_DONE] = s.rd_done;
    fe_need = s.sel == SSRB_ACT_FE_TEST || s.sel == SSRB_ACT_BOTH_TEST;
    lg_need = s.sel == SSRB_ACT_LOGIC_TEST || s.sel == SSRB_ACT_BOTH_TEST;
  end

  always_comb begin
    next_s = s;
    finish = 1'b0;
    next_s.turns_pulse = 1'b0;
    next_s.reset_pulse = 1'b0;
    next_s.pos_word = pos;

    // Three-stage filters: the level moves only when stages two and three agree.
    next_s.uvd_sync = {s.uvd_sync[1:0], i_uvd_pin};
    next_s.uva_sync = {s.uva_sync[1:0], i_uva_pin};
    if (s.uvd_sync[1] == s.uvd_sync[2]) begin
      next_s.uvd = s.uvd_sync[2];
    end
    if (s.uva_sync[1] == s.uva_sync[2]) begin
      next_s.uva = s.uva_sync[2];
    end

    // Register reads; a fault or caution read marks what a later wipe may clear.
    if (i_req.rd) begin
      unique case (i_req.addr)
        `SSRB_OFS_WRITE_TARGET: next_s.rdata = {8'h00, s.wr_target};
        `SSRB_OFS_WRITE_HIGH: next_s.rdata = s.wr_high;
        `SSRB_OFS_WRITE_LOW: next_s.rdata = s.wr_low;
        `SSRB_OFS_WRITE_CS: next_s.rdata = wr_cs;
        `SSRB_OFS_READ_TARGET: next_s.rdata = {8'h00, s.rd_target};
        `SSRB_OFS_READ_CS: next_s.rdata = rd_cs;
        `SSRB_OFS_READ_HIGH: next_s.rdata = s.rd_data[31:16];
        `SSRB_OFS_READ_LOW: next_s.rdata = s.rd_data[15:0];
        `SSRB_OFS_COMMAND: next_s.rdata = {s.sel, 12'h000};
        `SSRB_OFS_POSITION: next_s.rdata = pos;
        `SSRB_OFS_FAULT: begin
          next_s.rdata = {`SSRB_FAULT_ID, s.fault};
          next_s.fault_seen = s.fault;
        end
        `SSRB_OFS_CAUTION: begin
          next_s.rdata = {`SSRB_CAUTION_ID, s.caution};
          next_s.caution_seen = s.caution;
        end
        default: next_s.rdata = 16'h0000;
      endcase
    end

    // Register writes; clears come first so that events below win over them.
    if (i_req.wr) begin
      unique case (i_req.addr)
        `SSRB_OFS_WRITE_TARGET: next_s.wr_target = i_req.wdata[7:0];
        `SSRB_OFS_WRITE_HIGH: next_s.wr_high = i_req.wdata;
        `SSRB_OFS_WRITE_LOW: next_s.wr_low = i_req.wdata;
        `SSRB_OFS_WRITE_CS: begin
          if (i_req.wdata[`SSRB_BIT_START] && s.wr_op == SSRB_OP_IDLE) begin
            next_s.wr_op = SSRB_OP_WAIT;
            next_s.wr_done = 1'b0;
            next_s.wr_cnt = in_nvm(s.wr_target) ? WR_LOAD : 20'h00000;
          end
        end
        `SSRB_OFS_READ_TARGET: next_s.rd_target = i_req.wdata[7:0];
        `SSRB_OFS_READ_CS: begin
          if (i_req.wdata[`SSRB_BIT_START]) begin
            next_s.wr_done = 1'b0;
            if (s.rd_op == SSRB_OP_IDLE) begin
              next_s.rd_op = SSRB_OP_WAIT;
              next_s.rd_done = 1'b0;
              next_s.rd_cnt = in_nvm(s.rd_target) ? RD_LOAD : 20'h00000;
            end
          end
        end
        `SSRB_OFS_COMMAND: begin
          if (i_req.wdata[`SSRB_BIT_STATUS_WIPE]) begin
            next_s.task_done = 1'b0;
            next_s.boot_done = 1'b0;
          end
          if (i_req.wdata[`SSRB_BIT_CAUTION_WIPE]) begin
            next_s.caution = s.caution & ~s.caution_seen;
            next_s.caution_seen = 12'h000;
          end
          if (i_req.wdata[`SSRB_BIT_FAULT_WIPE]) begin
            next_s.fault = s.fault & ~s.fault_seen;
            next_s.fault_seen = 12'h000;
          end
          if (!s.act_run) begin
            next_s.sel = i_req.wdata[15:12];
            if (i_req.wdata[15:12] != s.sel) begin
              next_s.margin_on = 1'b0;
            end
            if (key_fires(i_req.wdata[15:12], i_req.wdata[7:0], i_unlocked)) begin
              next_s.act_run = 1'b1;
              next_s.task_done = 1'b0;
              next_s.fe_ok = 1'b0;
              next_s.lg_ok = 1'b0;
              unique case (i_req.wdata[15:12])
                SSRB_ACT_TURNS: next_s.turns_pulse = 1'b1;
                SSRB_ACT_HARD_RESET: next_s.reset_pulse = 1'b1;
                SSRB_ACT_RELOAD: begin
                  next_s.reload_run = 1'b1;
                  next_s.reload_idx = 5'h00;
                end
                SSRB_ACT_LOW_MARGIN, SSRB_ACT_HIGH_MARGIN: next_s.margin_on = 1'b1;
                default: next_s.margin_on = 1'b0;
              endcase
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Reload walks the whole memory into the shadow copy, one word a cycle.
    if (s.reload_run) begin
      next_s.shadow[s.reload_idx] = s.nvm[s.reload_idx];
      next_s.reload_idx = s.reload_idx + 5'h01;
      if (s.reload_idx == 5'h1F) begin
        next_s.reload_run = 1'b0;
      end
    end

    // Indirect write engine.
    unique case (s.wr_op)
      SSRB_OP_IDLE: begin
      end
      SSRB_OP_WAIT: begin
        if (s.wr_cnt == 20'h00000) begin
          next_s.wr_op = SSRB_OP_FINISH;
        end else begin
          next_s.wr_cnt = s.wr_cnt - 20'h00001;
        end
      end
      SSRB_OP_FINISH: begin
        if (in_nvm(s.wr_target)) begin
          next_s.nvm[s.wr_target[4:0]] = {s.wr_high, s.wr_low};
        end else if (in_shadow(s.wr_target)) begin
          next_s.shadow[s.wr_target[4:0]] = {s.wr_high, s.wr_low};
        end
        next_s.wr_op = SSRB_OP_IDLE;
        next_s.wr_done = 1'b1;
      end
      default: begin
        next_s.wr_op = SSRB_OP_IDLE;
      end
    endcase

    // Indirect read engine.
    unique case (s.rd_op)
      SSRB_OP_IDLE: begin
      end
      SSRB_OP_WAIT: begin
        if (s.rd_cnt == 20'h00000) begin
          next_s.rd_op = SSRB_OP_FINISH;
        end else begin
          next_s.rd_cnt = s.rd_cnt - 20'h00001;
        end
      end
      SSRB_OP_FINISH: begin
        if (in_nvm(s.rd_target)) begin
          next_s.rd_data = s.nvm[s.rd_target[4:0]];
        end else if (in_shadow(s.rd_target)) begin
          next_s.rd_data = s.shadow[s.rd_target[4:0]];
        end else begin
          next_s.rd_data = 32'h00000000;
        end
        next_s.rd_op = SSRB_OP_IDLE;
        next_s.rd_done = 1'b1;
      end
      default: begin
        next_s.rd_op = SSRB_OP_IDLE;
      end
    endcase

    // Action progress and completion.
    if (s.act_run) begin
      next_s.fe_ok = s.fe_ok | i_fe_test_done;
      next_s.lg_ok = s.lg_ok | i_logic_test_done;
      unique case (s.sel)
        SSRB_ACT_RELOAD: finish = !s.reload_run;
        SSRB_ACT_FE_TEST, SSRB_ACT_LOGIC_TEST, SSRB_ACT_BOTH_TEST: begin
          finish = (!fe_need || next_s.fe_ok) && (!lg_need || next_s.lg_ok);
        end
        default: finish = 1'b1;
      endcase
      if (finish) begin
        next_s.act_run = 1'b0;
        next_s.task_done = 1'b1;
        if (s.sel != SSRB_ACT_LOW_MARGIN && s.sel != SSRB_ACT_HIGH_MARGIN) begin
          next_s.sel = SSRB_ACT_NONE;
        end
      end
    end

    // Hardware events set flags after any clear in the same cycle.
    if (i_boot_done) begin
      next_s.boot_done = 1'b1;
    end
    next_s.fault = next_s.fault | i_fault_set;
    next_s.fault[`SSRB_BIT_UVD] = next_s.fault[`SSRB_BIT_UVD] | s.uvd;
    next_s.fault[`SSRB_BIT_UVA] = next_s.fault[`SSRB_BIT_UVA] | s.uva;
    next_s.caution = next_s.caution | i_caution_set;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_reg_rdata = s.rdata;
  assign o_position_word = s.pos_word;
  assign o_task_done = s.task_done;
  assign o_boot_done = s.boot_done;
  assign o_margin_low = s.margin_on && s.sel == SSRB_ACT_LOW_MARGIN;
  assign o_margin_high = s.margin_on && s.sel == SSRB_ACT_HIGH_MARGIN;
  assign o_turns_reset = s.turns_pulse;
  assign o_hard_reset = s.reset_pulse;
  assign o_fe_test_run = s.act_run && fe_need && !s.fe_ok;
  assign o_logic_test_run = s.act_run && lg_need && !s.lg_ok;
  assign o_reload_busy = s.reload_run;

endmodule

// File: sim/ssrb_chk.sv
// Purpose: Port checker for the sensor register bank.
// Assumes: One clock domain with an active-low reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module ssrb_chk
  import ssrb_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register bus.
  input wire logic i_ce,
  input wire ssrb_req_s i_req,
  input wire logic [15:0] o_reg_rdata,
  // Sensor side.
  input wire logic i_unlocked,
  input wire logic [11:0] i_angle,
  input wire logic [11:0] i_fault_mask,
  input wire logic [11:0] i_caution_mask,
  input wire logic [1:0] i_uv_mask,
  input wire logic [15:0] o_position_word,
  input wire logic o_task_done,
  input wire logic o_margin_low,
  input wire logic o_turns_reset,
  input wire logic o_hard_reset,
  input wire logic o_fe_test_run,
  input wire logic o_logic_test_run,
  input wire logic o_reload_busy
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic idle;
  logic turns_cmd;
  logic reload_tail;

  // A reload action ends one cycle after its walk, so that cycle still counts as busy.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reload_tail <= 1'b0;
    end else if (i_ce) begin
      reload_tail <= o_reload_busy;
    end
  end
  assign idle = !o_fe_test_run && !o_logic_test_run && !o_reload_busy && !reload_tail;
  assign turns_cmd = i_ce && i_req.wr && i_req.addr == 8'h1E && i_req.wdata[15:12] == 4'h3 && idle;

  pos_top_zero_a: assert property (o_position_word[15] == 1'b0)
    else $error("position word bit 15 set");
  pos_parity_a: assert property ($past(i_rst_n) |-> ^o_position_word)
    else $error("position word parity even");
  pos_angle_a: assert property ($past(i_rst_n) && $past(i_ce)
    |-> o_position_word[11:0] == $past(i_angle)) else $error("angle field wrong");
  uv_masked_a: assert property ($past(i_uv_mask) == 2'b11 |-> !o_position_word[13])
    else $error("masked undervoltage shown");
  ef_masked_a: assert property ($past(i_fault_mask) == 12'hFFF
    && $past(i_caution_mask) == 12'hFFF |-> !o_position_word[14]) else $error("masked error shown");
  turns_pulse_a: assert property (turns_cmd && i_req.wdata[7:0] == 8'h46
    |=> ##[0:1] o_turns_reset ##1 !o_turns_reset) else $error("turns pulse wrong");
  wrong_key_a: assert property (turns_cmd && i_req.wdata[7:0] != 8'h46
    |=> !o_turns_reset [*3]) else $error("turns pulse on wrong key");
  task_flag_a: assert property (turns_cmd && i_req.wdata[7:0] == 8'h46
    |=> !o_task_done ##[1:2] o_task_done) else $error("task flag sequence wrong");
  hard_lock_a: assert property ($rose(o_hard_reset)
    |-> $past(i_unlocked) || $past(i_unlocked, 2)) else $error("hard reset while locked");
  margin_lock_a: assert property ($rose(o_margin_low)
    |-> $past(i_unlocked) || $past(i_unlocked, 2)) else $error("margin while locked");
  ctl_read_a: assert property (i_ce && i_req.rd && i_req.addr inside {8'h08, 8'h0C}
    |=> o_reg_rdata[15:9] == 7'h00 && o_reg_rdata[7:1] == 7'h00) else $error("control bits nonzero");

  cover property (o_turns_reset);
  cover property (o_margin_low);
  cover property ($rose(o_task_done));
endmodule

bind ssrb_top ssrb_chk u_chk (.i_clk, .i_rst_n, .i_ce, .i_req, .o_reg_rdata, .i_unlocked,
  .i_angle, .i_fault_mask, .i_caution_mask, .i_uv_mask, .o_position_word, .o_task_done,
  .o_margin_low, .o_turns_reset, .o_hard_reset, .o_fe_test_run, .o_logic_test_run,
  .o_reload_busy);

// File: sim/ssrb_host.sv
// Purpose: Serial host model issuing register requests.
// Assumes: One-cycle request pulses taken on the rising edge.
// Notes: Released fields show the inverse of the last request.
`timescale 1ns/1ps
module ssrb_host
  import ssrb_pkg::*;
(
  // Clock.
  input wire logic i_clk,
  // Register bus.
  output ssrb_req_s o_req,
  input wire logic [15:0] i_rdata
);
  initial o_req = '0;

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_req <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk);
    o_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge i_clk);
    o_req <= '{1'b0, 1'b0, ~a, 16'hFFFF};
    #1;
    d = i_rdata;
  endtask

  // Data words are only touched once the done bit is seen.
  task automatic poll(input logic [7:0] a, input int b, output logic ok);
    logic [15:0] d;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      rd(a, d);
      ok = (d[b] === 1'b1);
    end
  endtask
endmodule

// File: sim/tb_top.sv
// Purpose: Self-checking bench of the sensor register bank.
// Assumes: Memory write time shortened to 20 cycles.
// Notes: The host model issues every register access.
`timescale 1ns/1ps
module tb_top
  import ssrb_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic ce = 1'b1;
  logic unl = 1'b0;
  logic boot = 1'b0;
  logic fe_done = 1'b0;
  logic lg_done = 1'b0;
  logic uvd = 1'b0;
  logic uva = 1'b0;
  logic [1:0] uv_mask = 2'b00;
  logic [11:0] angle = 12'h000;
  logic [11:0] f_set = 12'h000;
  logic [11:0] c_set = 12'h000;
  logic [11:0] f_mask = 12'h000;
  logic [11:0] c_mask = 12'h000;
  ssrb_req_s req;
  logic [15:0] rdata;
  logic [15:0] pos;
  logic task_done, boot_done, m_lo, m_hi, turns, hard, fe_run, lg_run, rl_busy;
  int num_errors = 0;
  int cmp_count = 0;

  always #25 i_clk = ~i_clk;

  ssrb_host host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata));

  ssrb_top #(.NVM_WR_CYC(20), .NVM_RD_CYC(40)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(ce), .i_req(req), .o_reg_rdata(rdata), .i_angle(angle), .i_unlocked(unl),
    .i_boot_done(boot), .i_fe_test_done(fe_done), .i_logic_test_done(lg_done),
    .i_fault_set(f_set), .i_caution_set(c_set), .i_fault_mask(f_mask),
    .i_caution_mask(c_mask), .i_uvd_pin(uvd), .i_uva_pin(uva), .i_uv_mask(uv_mask),
    .o_position_word(pos), .o_task_done(task_done), .o_boot_done(boot_done),
    .o_margin_low(m_lo), .o_margin_high(m_hi), .o_turns_reset(turns),
    .o_hard_reset(hard), .o_fe_test_run(fe_run), .o_logic_test_run(lg_run),
    .o_reload_busy(rl_busy));

  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic t_mem(input logic [7:0] t, input logic [15:0] hi, lo, input logic nvm);
    logic [15:0] d;
    logic ok;
    host.wr(8'h02, {8'h00, t});
    host.wr(8'h04, hi);
    host.wr(8'h06, lo);
    host.rd(8'h06, d);
    chk("write low", lo, d);
    host.wr(8'h08, 16'h8000);
    host.rd(8'h08, d);
    if (nvm) chk("write busy", 16'h0100, d);
    host.poll(8'h08, 0, ok);
    chk("write done", 16'h0001, {15'h0000, ok});
    if (!ok) stop_test();
    host.wr(8'h0A, {8'hFF, t});
    host.rd(8'h0A, d);
    chk("read target", {8'h00, t}, d);
    host.wr(8'h0C, 16'h8000);
    host.rd(8'h08, d);
    chk("write done cleared", 16'h0000, d);
    host.rd(8'h0C, d);
    if (nvm) chk("read busy", 16'h0100, d);
    host.poll(8'h0C, 0, ok);
    chk("read done", 16'h0001, {15'h0000, ok});
    if (!ok) stop_test();
    host.rd(8'h0E, d);
    chk("read high", hi, d);
    host.rd(8'h10, d);
    chk("read low", lo, d);
  endtask

  // Seen bits: task flag drop, reload, logic test, front end test, hard, turns, margins.
  task automatic t_act(input logic [3:0] s, input logic [7:0] k, input logic u,
                       input logic [7:0] e);
    logic [7:0] seen;
    logic [15:0] d;
    @(posedge i_clk);
    unl <= u;
    host.wr(8'h1E, 16'h0000);
    host.wr(8'h1E, {s, 4'h0, k});
    seen = 8'h00;
    for (int i = 0; i < 50; i++) begin
      @(posedge i_clk);
      seen |= {!task_done, rl_busy, lg_run, fe_run, hard, turns, m_hi, m_lo};
      fe_done <= (i == 8) && fe_run;
      lg_done <= (i == 12) && lg_run;
    end
    chk("actions", {8'h00, e}, {8'h00, seen});
    if (e != 8'h00) begin
      chk("task flag", 16'h0001, {15'h0000, task_done});
      host.rd(8'h1E, d);
      chk("select", {(s == 4'h1 || s == 4'h2) ? s : 4'h0, 12'h000}, d);
    end
  endtask

  task automatic pulse_set(input logic f, input logic [11:0] v);
    @(posedge i_clk);
    f_set <= f ? v : 12'h000;
    c_set <= f ? 12'h000 : v;
    @(posedge i_clk);
    f_set <= 12'h000;
    c_set <= 12'h000;
  endtask

  task automatic t_wipe(input logic f, input logic [3:0] id, input logic [15:0] w);
    logic [15:0] d;
    pulse_set(f, 12'h011);
    host.rd(f ? 8'h24 : 8'h26, d);
    chk("flags", {id, 12'h011}, d);
    pulse_set(f, 12'h100);
    host.wr(8'h1E, w);
    host.rd(f ? 8'h24 : 8'h26, d);
    chk("flags wiped", {id, 12'h100}, d);
    host.rd(8'h20, d);
    chk("error summary", 16'h0001, {15'h0000, d[14]});
  endtask

  task automatic t_pos(input logic [11:0] a, input logic [1:0] v, input logic [1:0] m);
    logic [15:0] d;
    logic u;
    @(posedge i_clk);
    angle <= a;
    uvd <= v[1];
    uva <= v[0];
    uv_mask <= m;
    repeat (8) @(posedge i_clk);
    host.rd(8'h20, d);
    u = |(v & ~m);
    chk("position", {2'b00, u, ~^{u, a}, a}, d);
    chk("position port", {2'b00, u, ~^{u, a}, a}, pos);
  endtask

  initial begin
    #4000000;
    num_errors++;
    stop_test();
  end

  initial begin
    logic [15:0] d;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_mem(8'h05, 16'h1234, 16'hABCD, 1'b1);
    t_mem(8'h41, 16'hC3A5, 16'h5A3C, 1'b0);
    t_act(4'h3, 8'h46, 1'b0, 8'h84);
    t_act(4'h3, 8'hA5, 1'b1, 8'h00);
    t_act(4'h1, 8'hA5, 1'b1, 8'h81);
    t_act(4'h2, 8'hA5, 1'b0, 8'h00);
    t_act(4'h2, 8'hA5, 1'b1, 8'h82);
    t_act(4'h4, 8'hA5, 1'b1, 8'hC0);
    t_act(4'h6, 8'h5A, 1'b1, 8'h88);
    t_act(4'h6, 8'h5A, 1'b0, 8'h00);
    t_act(4'h7, 8'hB9, 1'b1, 8'h90);
    t_act(4'h8, 8'hB9, 1'b1, 8'hA0);
    t_act(4'h9, 8'hB9, 1'b1, 8'hB0);
    t_act(4'h5, 8'hA5, 1'b1, 8'h00);
    t_wipe(1'b1, 4'hA, 16'h0100);
    t_wipe(1'b0, 4'hB, 16'h0200);
    @(posedge i_clk);
    boot <= 1'b1;
    @(posedge i_clk);
    boot <= 1'b0;
    @(posedge i_clk);
    chk("boot and task", 16'h0003, {14'h0000, boot_done, task_done});
    host.wr(8'h1E, 16'h0400);
    @(posedge i_clk);
    #1 chk("status wipe", 16'h0000, {14'h0000, boot_done, task_done});
    f_mask <= 12'hFFF;
    c_mask <= 12'hFFF;
    t_pos(12'h000, 2'b00, 2'b00);
    t_pos(12'hFFF, 2'b00, 2'b00);
    t_pos(12'h5A3, 2'b10, 2'b00);
    t_pos(12'h5A3, 2'b10, 2'b10);
    t_pos(12'h801, 2'b01, 2'b10);
    t_pos(12'h001, 2'b11, 2'b11);
    @(posedge i_clk);
    ce <= 1'b0;
    host.wr(8'h04, 16'h5555);
    ce <= 1'b1;
    host.rd(8'h04, d);
    chk("frozen write high", 16'hC3A5, d);
    host.rd(8'h12, d);
    chk("unmapped", 16'h0000, d);
    stop_test();
  end
endmodule
